// File: common/ferl_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the fault event record logger
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   record window is 5 slots of 10 words each
`ifndef FERL_MAP_SVH
`define FERL_MAP_SVH
`define FERL_CLK_PERIOD_NS     10
`define FERL_TICK_NS           1000000000
`define FERL_TICK_CYCLES       (`FERL_TICK_NS / `FERL_CLK_PERIOD_NS)
`define FERL_REC_BYTES         38
`define FERL_REC_SLOTS         5
`define FERL_REC_WORDS         10
`define FERL_CNT_MAX           4'hF
`define FERL_PCYC_MAX          16'hFFFF
// Register byte offsets
`define FERL_OFS_CTRL          12'h000
`define FERL_OFS_TIME          12'h004
`define FERL_OFS_STAT          12'h008
`define FERL_OFS_IRQ_STAT      12'h00C
`define FERL_OFS_IRQ_EN        12'h010
`define FERL_OFS_IRQ_CLR       12'h014
`define FERL_OFS_PCYC          12'h018
`define FERL_OFS_SDCNT         12'h01C
`define FERL_OFS_REC_BASE      12'h100
// Field positions
`define FERL_CTRL_EN_BIT       0
`define FERL_CTRL_EN_RST       1'b1
`define FERL_IRQ_LOG_BIT       0
`define FERL_IRQ_NVM_BIT       1
`define FERL_SD_UV             0
`define FERL_SD_THERM          1
`define FERL_SD_OC             2
`define FERL_SD_GEN            3
`define FERL_SD_FAN            4
`endif

// File: common/ferl_pkg.sv
// Purpose: shared types of the fault event record logger
// Assumes: used together with ferl_map.svh
// Notes:   a record is ten 32-bit words
package ferl_pkg;
   typedef logic [31:0] ferl_word_t;
   typedef ferl_word_t  ferl_rec_t [10];
endpackage

// File: rtl/ferl_logger.sv
// Purpose: capture fault event records and keep a five deep history readable over APB
// Assumes: sensor inputs are filtered and synchronous to pclk; pins pass two flops
// Notes:   record words: 0 time, 1 cycle counts, 2 status word+iout+input,
//          3 temp+fan status, 4-7 readings, 8-9 packed shutdown counters
// Functional notes
// RULE1: Time stamp is seconds since 1970
// RULE2: Mains cycle count only while request asserted
// RULE3: Request cycle count only while mains present
// RULE4: Snapshot status bytes and readings on event
// RULE5: Snapshot uses filtered sensor values
// RULE6: Copy all shutdown totals into record
// RULE7: Shutdown counters saturate at fifteen
// RULE8: Two counters packed per byte, fixed nibbles
// RULE9: Store shutdown counts on every event; nvm_counts holds four of the five counters, the thermal count is left out
// RULE10: Count each status bit assertion once
// RULE11: Record 38 bytes, newest plus four
// RULE12: New record shifts older, oldest dropped
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "ferl_map.svh"
module ferl_logger #(
   parameter int TICK_CYCLES = `FERL_TICK_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        power_on_request_n,
   input  wire logic        mains_ok,
   input  wire logic        output_on,
   input  wire logic [4:0]  shutdown_bits,
   input  wire logic        log_event,
   input  wire logic [15:0] status_word,
   input  wire logic [7:0]  status_iout,
   input  wire logic [7:0]  status_input,
   input  wire logic [7:0]  status_temp,
   input  wire logic [7:0]  status_fan,
   input  wire logic [15:0] rd_vin,
   input  wire logic [15:0] rd_iin,
   input  wire logic [15:0] rd_iout,
   input  wire logic [15:0] rd_temp1,
   input  wire logic [15:0] rd_temp2,
   input  wire logic [15:0] rd_fan1,
   input  wire logic [15:0] rd_pin,
   input  wire logic [15:0] rd_vout,
   input  wire logic        nvm_ready,
   output logic             nvm_store,
   output logic      [15:0] nvm_counts,
   output logic             irq
);
   import ferl_pkg::*;

   // Elaboration check: the seconds divider needs at least two cycles per tick
   if (TICK_CYCLES < 2) begin : g_tick_chk
      $error("TICK_CYCLES must be at least 2");
   end

   // Pin synchronisers; first stage read only by second stage
   logic [1:0] pon_s_q, ac_s_q, on_s_q;
   logic [4:0] sd_s1_q, sd_s2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pon_s_q <= 2'b11;
         ac_s_q  <= 2'b00;
         on_s_q  <= 2'b00;
         sd_s1_q <= 5'h0_0;
         sd_s2_q <= 5'h0_0;
      end else begin
         pon_s_q <= {pon_s_q[0], power_on_request_n};
         ac_s_q  <= {ac_s_q[0], mains_ok};
         on_s_q  <= {on_s_q[0], output_on};
         sd_s1_q <= shutdown_bits;
         sd_s2_q <= sd_s1_q;
      end
   end
   logic req_on, ac_on, out_on;
   assign req_on = !pon_s_q[1];
   assign ac_on  = ac_s_q[1];
   assign out_on = on_s_q[1];

   // Saturating increment helpers
   function automatic logic [3:0] sat4(input logic [3:0] v);
      return (v == `FERL_CNT_MAX) ? v : v + 4'h1;
   endfunction
   function automatic logic [15:0] sat16(input logic [15:0] v);
      return (v == `FERL_PCYC_MAX) ? v : v + 16'h0001;
   endfunction

   // Register state
   logic               en_q, en_d;
   logic [31:0]        time_q, time_d;
   logic [31:0]        tick_q, tick_d;
   logic [15:0]        ac_cyc_q, ac_cyc_d, ps_cyc_q, ps_cyc_d;
   logic               prev_on_q, prev_on_d;
   logic               off_ac_q, off_ac_d, off_ps_q, off_ps_d;
   logic [4:0]         sd_prev_q;
   logic [3:0]         cnt_q [5];
   logic [3:0]         cnt_d [5];
   ferl_rec_t          rec_q [5];
   ferl_rec_t          rec_d [5];
   logic [1:0]         ist_q, ist_d, ien_q, ien_d;
   logic               pend_q, pend_d;
   logic [31:0]        rdata_d;
   logic               serr_d;

   // Decode in the setup cycle so read data and error stand through the access phase
   logic wr, setup;
   assign wr     = psel && penable && pwrite;
   assign setup  = psel && !penable;
   assign pready = psel && penable;  // Zero wait state slave

   logic [4:0] sd_rise;
   assign sd_rise = sd_s2_q & ~sd_prev_q;  // RULE10

   // Packed counter words, used only by record words 8 and 9
   logic [15:0] packed_cnt;
   assign packed_cnt = {4'h0, cnt_d[`FERL_SD_FAN],
                        cnt_d[`FERL_SD_GEN], cnt_d[`FERL_SD_OC]};  // RULE8
   logic [7:0]  packed_uv;
   assign packed_uv = {cnt_d[`FERL_SD_THERM], cnt_d[`FERL_SD_UV]};  // RULE8

   // Next state of every counter, record and register except sd_prev_q
   always_comb begin
      logic [11:0] ofs;
      int          slot;
      int          wd;
      ofs      = paddr;
      slot     = 0;
      wd       = 0;
      en_d     = en_q;
      time_d   = time_q;
      tick_d   = tick_q;
      ac_cyc_d = ac_cyc_q;
      ps_cyc_d = ps_cyc_q;
      prev_on_d = out_on;
      off_ac_d = off_ac_q;
      off_ps_d = off_ps_q;
      cnt_d    = cnt_q;
      rec_d    = rec_q;
      ist_d    = ist_q;
      ien_d    = ien_q;
      pend_d   = pend_q;
      rdata_d  = 32'h0000_0000;
      serr_d   = 1'b0;
      // Seconds tick; software loads the clock, hardware keeps it running
      if (tick_q == 32'(TICK_CYCLES - 1)) begin
         tick_d = 32'h0000_0000;
         time_d = time_q + 32'h0000_0001;  // RULE1
      end else begin
         tick_d = tick_q + 32'h0000_0001;
      end
      // Note why the output went off, count on its return
      if (prev_on_q && !out_on) begin
         off_ac_d = !ac_on && req_on;
         off_ps_d = !req_on && ac_on;
      end
      if (!prev_on_q && out_on) begin
         if (off_ac_q && req_on) ac_cyc_d = sat16(ac_cyc_q);  // RULE2
         if (off_ps_q && ac_on) ps_cyc_d = sat16(ps_cyc_q);   // RULE3
         off_ac_d = 1'b0;
         off_ps_d = 1'b0;
      end
      for (int i = 0; i < 5; i++) begin
         if (sd_rise[i]) cnt_d[i] = sat4(cnt_q[i]);  // RULE7
      end
      if (|sd_rise) begin
         pend_d = 1'b1;                              // RULE9
         ist_d[`FERL_IRQ_NVM_BIT] = 1'b1;
      end
      if (pend_q && nvm_ready) pend_d = |sd_rise;
      // Logged event: shift history, place new record
      if (log_event && en_q) begin
         for (int s = 4; s > 0; s--) rec_d[s] = rec_q[s-1];  // RULE12
         rec_d[0][0] = time_d;                              // RULE1
         rec_d[0][1] = {ps_cyc_d, ac_cyc_d};                // RULE2 RULE3
         rec_d[0][2] = {status_input, status_iout, status_word};  // RULE4 RULE5
         rec_d[0][3] = {16'h0000, status_fan, status_temp};       // RULE4
         rec_d[0][4] = {rd_iin, rd_vin};                          // RULE4 RULE5
         rec_d[0][5] = {rd_temp1, rd_iout};
         rec_d[0][6] = {rd_fan1, rd_temp2};
         rec_d[0][7] = {rd_vout, rd_pin};
         rec_d[0][8] = {24'h00_0000, packed_uv};                  // RULE6
         rec_d[0][9] = {16'h0000, packed_cnt};                    // RULE6
         ist_d[`FERL_IRQ_LOG_BIT] = 1'b1;
      end
      // APB writes
      if (wr) begin
         case (ofs)
            `FERL_OFS_CTRL:    en_d = pwdata[`FERL_CTRL_EN_BIT];
            `FERL_OFS_TIME:    begin
               time_d = pwdata;
               tick_d = 32'h0000_0000;
            end
            `FERL_OFS_IRQ_EN:  ien_d = pwdata[1:0];
            `FERL_OFS_IRQ_CLR: begin
               // A set on a bit that was clear wins over a same-cycle clear
               ist_d = ist_d & ~(pwdata[1:0] & ~(ist_d & ~ist_q));
            end
            default:           begin end
         endcase
      end
      // Write error decode; the record window takes writes silently
      if (setup && pwrite) begin
         case (ofs)
            `FERL_OFS_CTRL, `FERL_OFS_TIME, `FERL_OFS_IRQ_EN, `FERL_OFS_IRQ_CLR: serr_d = 1'b0;
            default: serr_d = (ofs < `FERL_OFS_REC_BASE);
         endcase
      end
      // APB reads
      if (setup && !pwrite) begin
         case (ofs)
            `FERL_OFS_CTRL:     rdata_d = {31'h0000_0000, en_q};
            `FERL_OFS_TIME:     rdata_d = time_q;
            `FERL_OFS_STAT:     rdata_d = {29'h0000_0000, pend_q, ac_on, req_on};
            `FERL_OFS_IRQ_STAT: rdata_d = {30'h0000_0000, ist_q};
            `FERL_OFS_IRQ_EN:   rdata_d = {30'h0000_0000, ien_q};
            `FERL_OFS_PCYC:     rdata_d = {ps_cyc_q, ac_cyc_q};
            `FERL_OFS_SDCNT:    rdata_d = {12'h000, cnt_q[4], cnt_q[3], cnt_q[2], cnt_q[1], cnt_q[0]};
            default: begin
               // Record window: 5 slots x 10 words, newest first
               if (ofs >= `FERL_OFS_REC_BASE &&
                   ofs < 12'(`FERL_OFS_REC_BASE + 4 * `FERL_REC_SLOTS * `FERL_REC_WORDS)) begin
                  wd   = int'((ofs - `FERL_OFS_REC_BASE) >> 2);
                  slot = wd / `FERL_REC_WORDS;
                  rdata_d = rec_q[slot][wd % `FERL_REC_WORDS];  // RULE11
               end else begin
                  serr_d = 1'b1;
               end
            end
         endcase
      end
   end

   // Register everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q      <= `FERL_CTRL_EN_RST;
         time_q    <= 32'h0000_0000;
         tick_q    <= 32'h0000_0000;
         ac_cyc_q  <= 16'h0000;
         ps_cyc_q  <= 16'h0000;
         prev_on_q <= 1'b0;
         off_ac_q  <= 1'b0;
         off_ps_q  <= 1'b0;
         sd_prev_q <= 5'h0_0;
         ist_q     <= 2'h0;
         ien_q     <= 2'h0;
         pend_q    <= 1'b0;
         prdata    <= 32'h0000_0000;
         pslverr   <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            cnt_q[i] <= 4'h0;
            for (int j = 0; j < 10; j++) rec_q[i][j] <= 32'h0000_0000;
         end
      end else begin
         en_q      <= en_d;
         time_q    <= time_d;
         tick_q    <= tick_d;
         ac_cyc_q  <= ac_cyc_d;
         ps_cyc_q  <= ps_cyc_d;
         prev_on_q <= prev_on_d;
         off_ac_q  <= off_ac_d;
         off_ps_q  <= off_ps_d;
         sd_prev_q <= sd_s2_q;
         ist_q     <= ist_d;
         ien_q     <= ien_d;
         pend_q    <= pend_d;
         cnt_q     <= cnt_d;
         rec_q     <= rec_d;
         if (setup && !pwrite) prdata <= rdata_d;
         if (setup) pslverr <= serr_d;
      end
   end

   // Store request to non-volatile memory follows pending flag
   assign nvm_store  = pend_q;                               // RULE9
   assign nvm_counts = {cnt_q[4], cnt_q[3] , cnt_q[2], cnt_q[0]};
   assign irq        = |(ist_q & ien_q);

   // Checks
   cnt_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_q[0] == `FERL_CNT_MAX |=> cnt_q[0] == `FERL_CNT_MAX)
      else $error("counter left saturation");  // RULE7
   cnt_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
      sd_rise[1] && cnt_q[1] != `FERL_CNT_MAX |=> cnt_q[1] == $past(cnt_q[1]) + 4'h1)
      else $error("counter missed an assertion");  // RULE10
   cnt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !sd_rise[2] |=> $stable(cnt_q[2]))
      else $error("counter moved without assertion");  // RULE10
   rec_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
      log_event && en_q |=> rec_q[4][0] == $past(rec_q[3][0]) && rec_q[1][2] == $past(rec_q[0][2]))
      else $error("history did not shift");  // RULE12
   rec_snap_a: assert property (@(posedge pclk) disable iff (!presetn)
      log_event && en_q |=> rec_q[0][4] == $past({rd_iin, rd_vin}) && rec_q[0][2][15:0] == $past(status_word))
      else $error("snapshot wrong");  // RULE4
   rec_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
      log_event && en_q |=> rec_q[0][8][7:4] == cnt_q[`FERL_SD_THERM] && rec_q[0][9][11:8] == cnt_q[`FERL_SD_FAN])
      else $error("packed counters wrong");  // RULE8
   nvm_req_a: assert property (@(posedge pclk) disable iff (!presetn)
      |sd_rise |=> nvm_store)
      else $error("store not requested");  // RULE9
   time_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q == 32'(TICK_CYCLES - 1) && !wr |=> time_q == $past(time_q) + 32'h0000_0001)
      else $error("seconds did not advance");  // RULE1
   ac_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
      !req_on && !$past(req_on) |=> ac_cyc_q == $past(ac_cyc_q) || $past(!prev_on_q && out_on))
      else $error("mains count advanced without request");  // RULE2
endmodule // ferl_logger

// File: sim/ferl_nvm_model.sv
// Purpose: memory responder that accepts the shutdown count store
// Assumes: the store request is a level held until accepted
// Notes:   slow mode stretches the write time so the request must stay up
`timescale 1ns/1ps
module ferl_nvm_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic nvm_store,
   input  wire logic slow,
   output logic      nvm_ready,
   output int        accepts
);
   int wait_q;
   // One cycle of ready per accepted store, after a short or long write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q    <= 0;
         nvm_ready <= 1'b0;
         accepts   <= 0;
      end else begin
         nvm_ready <= 1'b0;
         if (nvm_store && !nvm_ready) begin
            wait_q <= wait_q + 1;
            if (wait_q >= (slow ? 12 : 1)) begin
               nvm_ready <= 1'b1;
               accepts   <= accepts + 1;
               wait_q    <= 0;
            end
         end
      end
   end
endmodule // ferl_nvm_model

// File: sim/ferl_logger_tb.sv
// Purpose: self-checking bench of the fault event record logger
// Assumes: zero wait APB, read data and error taken at the access edge
// Notes:   a short tick parameter keeps the seconds counter fast
`timescale 1ns/1ps
`include "ferl_map.svh"
module ferl_logger_tb;
   import ferl_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, log_event, req_n, mains_ok, output_on, slow;
   logic        pready, pslverr, nvm_ready, nvm_store, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] nvm_counts, sw;
   logic [7:0]  si, sn, st, sf;
   logic [15:0] rd [8];
   logic [4:0]  sd_bits;
   int          error_cnt, compares, accepts;
   ferl_word_t  got;
   logic        got_err;
   ferl_rec_t   exp1, old1;
   ferl_logger #(.TICK_CYCLES(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_on_request_n(req_n), .mains_ok(mains_ok), .output_on(output_on), .shutdown_bits(sd_bits),
      .log_event(log_event), .status_word(sw), .status_iout(si), .status_input(sn), .status_temp(st),
      .status_fan(sf), .rd_vin(rd[0]), .rd_iin(rd[1]), .rd_iout(rd[2]), .rd_temp1(rd[3]), .rd_temp2(rd[4]),
      .rd_fan1(rd[5]), .rd_pin(rd[6]), .rd_vout(rd[7]), .nvm_ready(nvm_ready), .nvm_store(nvm_store),
      .nvm_counts(nvm_counts), .irq(irq));
   ferl_nvm_model nvm (.pclk(pclk), .presetn(presetn), .nvm_store(nvm_store), .slow(slow),
      .nvm_ready(nvm_ready), .accepts(accepts));
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // One APB transfer; read data and error are taken at the edge that sees pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      got     = prdata;
      got_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [11:0] rec(input int slot, input int w);
      return 12'h100 + 12'(slot * 40 + w * 4);
   endfunction
   // Present a snapshot and pulse the capture request; expected words follow the packing
   task automatic log_rec(input logic [15:0] s);
      sw <= s;
      si <= s[7:0];
      sn <= s[15:8];
      st <= ~s[7:0];
      sf <= ~s[15:8];
      for (int i = 0; i < 8; i++) rd[i] <= s + 16'(i * 16'h0101);
      exp1[2] = {s[15:8], s[7:0], s};
      exp1[3] = {16'h0000, ~s[15:8], ~s[7:0]};
      for (int k = 4; k < 8; k++) exp1[k] = {s + 16'((2 * k - 7) * 16'h0101), s + 16'((2 * k - 8) * 16'h0101)};
      @(posedge pclk);
      log_event <= 1'b1;
      @(posedge pclk);
      log_event <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic pulse_sd(input int b);
      sd_bits[b] <= 1'b1;
      repeat (6) @(posedge pclk);
      sd_bits[b] <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask
   task automatic t_regs;
      apb(1'b0, `FERL_OFS_CTRL, 32'h0000_0000);
      check(got[0], `FERL_CTRL_EN_RST);
      check(got_err, 1'b0);
      apb(1'b0, `FERL_OFS_IRQ_STAT, 32'h0000_0000);
      check(got, 32'h0000_0000);
      apb(1'b0, 12'h080, 32'h0000_0000);
      check(got_err, 1'b1);
      apb(1'b1, `FERL_OFS_STAT, 32'h0000_0000);
      check(got_err, 1'b1);
      apb(1'b1, `FERL_OFS_IRQ_EN, 32'h0000_0003);
      check(got_err, 1'b0);
      $display("TB: registers done");
   endtask
   // Two mains losses and one request drop, then a record with time and snapshot
   task automatic t_cycles;
      for (int i = 0; i < 3; i++) begin
         if (i < 2) mains_ok <= 1'b0;
         else req_n <= 1'b1;
         output_on <= 1'b0;
         repeat (8) @(posedge pclk);
         mains_ok  <= 1'b1;
         req_n     <= 1'b0;
         output_on <= 1'b1;
         repeat (8) @(posedge pclk);
      end
      apb(1'b1, `FERL_OFS_TIME, 32'h6000_0000);
      log_rec(16'hA55A);
      apb(1'b0, rec(0, 0), 32'h0000_0000);
      check(32'(got - 32'h6000_0000 <= 32'd1), 32'd1);
      apb(1'b0, rec(0, 1), 32'h0000_0000);
      check(got, {16'd1, 16'd2});
      for (int k = 2; k < 8; k++) begin
         apb(1'b0, rec(0, k), 32'h0000_0000);
         check(k == 3 ? {16'h0000, got[15:0]} : got, exp1[k]);
      end
      apb(1'b0, `FERL_OFS_PCYC, 32'h0000_0000);
      check(got, {16'd1, 16'd2});
      old1 = exp1;
      $display("TB: cycles and snapshot done");
   endtask
   task automatic t_irq;
      check(irq, 1'b1);
      apb(1'b0, `FERL_OFS_IRQ_STAT, 32'h0000_0000);
      check(got[0], 1'b1);
      // Irq is looked at mid-cycle, once the enable or clear has been registered
      apb(1'b1, `FERL_OFS_IRQ_EN, 32'h0000_0000);
      @(negedge pclk);
      check(irq, 1'b0);
      apb(1'b1, `FERL_OFS_IRQ_EN, 32'h0000_0003);
      @(negedge pclk);
      check(irq, 1'b1);
      apb(1'b1, `FERL_OFS_IRQ_CLR, 32'h0000_0003);
      @(negedge pclk);
      check(irq, 1'b0);
      @(posedge pclk);
      $display("TB: interrupt done");
   endtask
   // Saturating nibble counters, the slow store, then a second record shifting the first
   task automatic t_counts;
      int n [5] = '{16, 4, 2, 1, 3};
      slow <= 1'b1;
      for (int b = 0; b < 5; b++) for (int i = 0; i < n[b]; i++) pulse_sd(b);
      repeat (20) @(posedge pclk);
      check(nvm_counts, 16'h312F);
      check(nvm_store, 1'b0);
      check(32'(accepts > 0), 32'd1);
      apb(1'b0, `FERL_OFS_STAT, 32'h0000_0000);
      check(got[2:0], 3'b011);
      apb(1'b0, `FERL_OFS_SDCNT, 32'h0000_0000);
      check(got, 32'h0003_124F);
      log_rec(16'h1234);
      apb(1'b0, rec(0, 8), 32'h0000_0000);
      check(got[7:0], 8'h4F);
      apb(1'b0, rec(0, 9), 32'h0000_0000);
      check(got[11:0], 12'h312);
      apb(1'b0, rec(0, 2), 32'h0000_0000);
      check(got, exp1[2]);
      apb(1'b1, rec(1, 2), 32'hFFFF_FFFF);
      apb(1'b0, rec(1, 2), 32'h0000_0000);
      check(got, old1[2]);
      apb(1'b0, `FERL_OFS_IRQ_STAT, 32'h0000_0000);
      check(got[1:0], 2'b11);
      // With logging disabled a capture request leaves the history alone
      old1 = exp1;
      apb(1'b1, `FERL_OFS_CTRL, 32'h0000_0000);
      log_rec(16'h0F0F);
      apb(1'b0, rec(0, 2), 32'h0000_0000);
      check(got, old1[2]);
      $display("TB: counters and history done");
   endtask
   task automatic report_and_stop;
      $display("TB: %0d compares, %0d errors", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Watchdog well beyond the few hundred cycles the tests take
   initial begin
      #200000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      {presetn, psel, penable, pwrite, log_event, req_n, slow, sd_bits} = '0;
      {mains_ok, output_on} = 2'b11;
      {paddr, pwdata, sw, si, sn, st, sf} = '0;
      for (int i = 0; i < 8; i++) rd[i] = 16'h0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      t_regs();
      t_cycles();
      t_irq();
      t_counts();
      report_and_stop();
   end
endmodule // ferl_logger_tb
